// ---- logic/pdc_params.svh ----
// Overview of operation
// - Direction 0: driver off, reads return pin
// - Direction 1: driver on, reads return latch
// - Input pin pull follows its pull enable
// - Output pins never get a pull device
// - Pull-down only for selected rising-polarity pins
// - Slew bit limits slew on outputs only
// - Drive bit picks strength on outputs only
// - Flag bit 3 set by detection, writes ignored
// - Acknowledge bit 2 clears flag, reads zero
// - Request only when enable and flag set
// - Mode bit 0: edges only, or edges and levels
// - Edge select picks polarity and pull direction
// - Only selected pins can set the flag
// - Reset clears latches, all pins unpulled inputs
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH
// ============================================================
// Register byte offsets
`define PDC_OFF_DATA 12'h000
`define PDC_OFF_DIR 12'h004
`define PDC_OFF_PULL 12'h008
`define PDC_OFF_SLEW 12'h00c
`define PDC_OFF_DRIVE 12'h010
`define PDC_OFF_SC 12'h014
`define PDC_OFF_PSEL 12'h018
`define PDC_OFF_ESEL 12'h01c
// ============================================================
// Status/control field positions
`define PDC_SC_FLAG 3
`define PDC_SC_ACK 2
`define PDC_SC_IE 1
`define PDC_SC_MOD 0
// ============================================================
// Reset values
`define PDC_RST_BYTE 8'h00
`define PDC_RST_SLEW 8'h00
// ============================================================
// AXI responses
`define PDC_RESP_OKAY 2'b00
`define PDC_RESP_SLVERR 2'b10
`endif

// ---- logic/pdc_pkg.sv ----
package pdc_pkg;
  typedef logic [7:0] pdc_byte_t;
  typedef logic [1:0] pdc_resp_t;
endpackage

// ---- logic/pdc_detect.sv ----
`timescale 1ns/1ps
`include "pdc_params.svh"
module pdc_detect
  import pdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire pdc_byte_t pin_level,
  input wire pdc_byte_t irq_pin_select,
  input wire pdc_byte_t irq_edge_polarity_select,
  input wire logic edge_level_detect_mode,
  input wire logic ack_pulse,
  output logic pin_irq_flag
);
  pdc_byte_t prev_r;
  pdc_byte_t active;
  logic edge_hit;
  logic level_hit;
  logic hit;
  // Polarity folded so that 1 always means active level
  assign active = ~(pin_level ^ irq_edge_polarity_select);
  assign edge_hit = |(active & ~prev_r & irq_pin_select);
  assign level_hit = edge_level_detect_mode && |(active & irq_pin_select);
  assign hit = edge_hit || level_hit;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_r <= 8'hff;
    else
      prev_r <= active;
  end
  // Set beats acknowledge in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_irq_flag <= 1'b0;
    else if (hit)
      pin_irq_flag <= 1'b1;
    else if (ack_pulse)
      pin_irq_flag <= 1'b0;
  end
endmodule // pdc_detect

// ---- logic/pdc_port.sv ----
`timescale 1ns/1ps
`include "pdc_params.svh"
module pdc_port
  import pdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pdc_byte_t pin_in,
  output pdc_byte_t pin_out,
  output pdc_byte_t pin_oe,
  output pdc_byte_t pull_up_en,
  output pdc_byte_t pull_down_en,
  output pdc_byte_t slew_limit_en,
  output pdc_byte_t high_drive_en,
  output logic pin_irq_request
);
  // ============================================================
  // Registers
  pdc_byte_t port_data_latch_r;
  pdc_byte_t pin_direction_r;
  pdc_byte_t pull_enable_r;
  pdc_byte_t slew_rate_enable_r;
  pdc_byte_t drive_strength_select_r;
  pdc_byte_t irq_pin_select_r;
  pdc_byte_t irq_edge_polarity_select_r;
  logic pin_irq_enable_r;
  logic edge_level_detect_mode_r;
  pdc_byte_t sync1_r;
  pdc_byte_t sync2_r;
  pdc_byte_t sync3_r;
  pdc_byte_t pin_level_r;
  logic pin_irq_flag;
  logic ack_pulse;
  // ============================================================
  // Bus handshake
  logic [11:0] awaddr_r;
  logic aw_held_r;
  pdc_byte_t wdata_r;
  logic wstrb0_r;
  logic w_held_r;
  logic do_write;
  logic rd_take;
  pdc_byte_t rd_byte;
  logic rd_ok;
  logic [11:0] rd_addr;

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == `PDC_OFF_DATA) || (a == `PDC_OFF_DIR) || (a == `PDC_OFF_PULL)
      || (a == `PDC_OFF_SLEW) || (a == `PDC_OFF_DRIVE) || (a == `PDC_OFF_SC)
      || (a == `PDC_OFF_PSEL) || (a == `PDC_OFF_ESEL);
  endfunction

  function automatic logic wr_hit(input logic [11:0] off);
    wr_hit = do_write && wstrb0_r && (awaddr_r == off);
  endfunction

  // A held pair is written only once the previous response has gone
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  // Word address; byte offsets within a word read the whole word
  assign rd_addr = {s_axi_araddr[11:2], 2'b00};
  assign ack_pulse = wr_hit(`PDC_OFF_SC) && wdata_r[`PDC_SC_ACK];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
    begin
      aw_held_r <= 1'b0;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r <= {s_axi_awaddr[11:2], 2'b00};
      s_axi_awready <= 1'b0;
    end
    else
      s_axi_awready <= !aw_held_r && !s_axi_bvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
    begin
      w_held_r <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata[7:0];
      wstrb0_r <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end
    else
      s_axi_wready <= !w_held_r && !s_axi_bvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PDC_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_known(awaddr_r) ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ============================================================
  // Register writes; byte lane 0 carries all fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_data_latch_r <= `PDC_RST_BYTE;
      pin_direction_r <= `PDC_RST_BYTE;
      pull_enable_r <= `PDC_RST_BYTE;
      slew_rate_enable_r <= `PDC_RST_SLEW;
      drive_strength_select_r <= `PDC_RST_BYTE;
      irq_pin_select_r <= `PDC_RST_BYTE;
      irq_edge_polarity_select_r <= `PDC_RST_BYTE;
      pin_irq_enable_r <= 1'b0;
      edge_level_detect_mode_r <= 1'b0;
    end
    else
    begin
      if (wr_hit(`PDC_OFF_DATA))
        port_data_latch_r <= wdata_r;
      if (wr_hit(`PDC_OFF_DIR))
        pin_direction_r <= wdata_r;
      if (wr_hit(`PDC_OFF_PULL))
        pull_enable_r <= wdata_r;
      if (wr_hit(`PDC_OFF_SLEW))
        slew_rate_enable_r <= wdata_r;
      if (wr_hit(`PDC_OFF_DRIVE))
        drive_strength_select_r <= wdata_r;
      if (wr_hit(`PDC_OFF_PSEL))
        irq_pin_select_r <= wdata_r;
      if (wr_hit(`PDC_OFF_ESEL))
        irq_edge_polarity_select_r <= wdata_r;
      if (wr_hit(`PDC_OFF_SC))
      begin
        pin_irq_enable_r <= wdata_r[`PDC_SC_IE];
        edge_level_detect_mode_r <= wdata_r[`PDC_SC_MOD];
      end
    end
  end

  // ============================================================
  // Pin input synchroniser; change accepted when stages 2 and 3 agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
      sync3_r <= 8'h00;
      pin_level_r <= 8'h00;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // Hold the accepted level while stages 2 and 3 disagree;
      // a pulse shorter than two clocks never reaches the detector
      pin_level_r <= (sync2_r & ~(sync2_r ^ sync3_r))
        | (pin_level_r & (sync2_r ^ sync3_r));
    end
  end

  pdc_detect u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_level(pin_level_r),
    .irq_pin_select(irq_pin_select_r),
    .irq_edge_polarity_select(irq_edge_polarity_select_r),
    .edge_level_detect_mode(edge_level_detect_mode_r),
    .ack_pulse(ack_pulse),
    .pin_irq_flag(pin_irq_flag)
  );

  // ============================================================
  // Read path
  // Decoded from the live address and registered at the handshake
  always_comb
  begin
    rd_ok = 1'b1;
    if (rd_addr == `PDC_OFF_DATA)
      rd_byte = (pin_direction_r & port_data_latch_r) | (~pin_direction_r & pin_level_r);
    else if (rd_addr == `PDC_OFF_DIR)
      rd_byte = pin_direction_r;
    else if (rd_addr == `PDC_OFF_PULL)
      rd_byte = pull_enable_r;
    else if (rd_addr == `PDC_OFF_SLEW)
      rd_byte = slew_rate_enable_r;
    else if (rd_addr == `PDC_OFF_DRIVE)
      rd_byte = drive_strength_select_r;
    else if (rd_addr == `PDC_OFF_SC)
      rd_byte = {4'h0, pin_irq_flag, 1'b0, pin_irq_enable_r, edge_level_detect_mode_r};
    else if (rd_addr == `PDC_OFF_PSEL)
      rd_byte = irq_pin_select_r;
    else if (rd_addr == `PDC_OFF_ESEL)
      rd_byte = irq_edge_polarity_select_r;
    else
    begin
      rd_byte = 8'h00;
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PDC_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_ok ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end

  // ============================================================
  // Pad controls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pull_up_en <= 8'h00;
      pull_down_en <= 8'h00;
      slew_limit_en <= 8'h00;
      high_drive_en <= 8'h00;
      pin_irq_request <= 1'b0;
    end
    else
    begin
      pin_out <= port_data_latch_r;
      pin_oe <= pin_direction_r;
      // Pull-down only on selected pins with rising polarity
      pull_up_en <= pull_enable_r & ~pin_direction_r
        & ~(irq_pin_select_r & irq_edge_polarity_select_r);
      pull_down_en <= pull_enable_r & ~pin_direction_r
        & irq_pin_select_r & irq_edge_polarity_select_r;
      slew_limit_en <= slew_rate_enable_r & pin_direction_r;
      high_drive_en <= drive_strength_select_r & pin_direction_r;
      pin_irq_request <= pin_irq_enable_r & pin_irq_flag;
    end
  end
endmodule // pdc_port

// ---- testbench/pdc_port_chk.sv ----
`timescale 1ns/1ps
module pdc_port_chk
  import pdc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire pdc_byte_t pin_oe,
  input wire pdc_byte_t pull_up_en,
  input wire pdc_byte_t pull_down_en,
  input wire pdc_byte_t slew_limit_en,
  input wire pdc_byte_t high_drive_en,
  input wire logic pin_irq_request
);
  // ============================================================
  // Port rules
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  pull_out_off_a: assert property (((pull_up_en | pull_down_en) & pin_oe) == 8'h00)
    else $error("pull device on a driven pin");
  pull_one_way_a: assert property ((pull_up_en & pull_down_en) == 8'h00)
    else $error("pull-up and pull-down together");
  slew_out_only_a: assert property ((slew_limit_en & ~pin_oe) == 8'h00)
    else $error("slew limit on an input pin");
  drive_out_only_a: assert property ((high_drive_en & ~pin_oe) == 8'h00)
    else $error("high drive on an input pin");
  rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=> pin_oe == 8'h00 &&
    pull_up_en == 8'h00 && pull_down_en == 8'h00 && !pin_irq_request)
    else $error("pins not quiet after reset");
  // Only a register write may drop a pending request
  irq_sticky_a: assert property (pin_irq_request && !s_axi_bvalid |=> pin_irq_request)
    else $error("request dropped without a write");
  read_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
endmodule // pdc_port_chk

bind pdc_port pdc_port_chk chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .pin_oe, .pull_up_en,
  .pull_down_en, .slew_limit_en, .high_drive_en, .pin_irq_request);

// ---- testbench/pdc_pins.sv ----
`timescale 1ns/1ps
module pdc_pins
  import pdc_pkg::*;
(
  input wire logic aclk,
  input wire pdc_byte_t pin_out,
  input wire pdc_byte_t pin_oe,
  input wire pdc_byte_t pull_up_en,
  input wire pdc_byte_t pull_down_en,
  input wire pdc_byte_t ext_val,
  input wire pdc_byte_t ext_en,
  output pdc_byte_t pin_in
);
  // Undriven, unpulled pins toggle every clock, so the synchroniser holds their last accepted level
  pdc_byte_t wander_r = 8'h55;
  always_ff @(posedge aclk)
  begin
    wander_r <= ~wander_r;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
    (~pin_oe & ~ext_en & (pull_up_en | (~pull_down_en & wander_r)));
endmodule // pdc_pins

// ---- testbench/pdc_port_tb_top.sv ----
`timescale 1ns/1ps
`include "pdc_params.svh"
module pdc_port_tb_top
  import pdc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  pdc_byte_t pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, slew_limit_en, high_drive_en;
  pdc_byte_t ext_val = 8'hff, ext_en = 8'h00;
  logic pin_irq_request;
  int err_total = 0, comparisons = 0, cycles = 0;
  initial forever #50 aclk = ~aclk;
  pdc_port uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe, .pull_up_en,
    .pull_down_en, .slew_limit_en, .high_drive_en, .pin_irq_request);
  pdc_pins pins (.aclk, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .ext_val, .ext_en,
    .pin_in);
  // ============================================================
  // Bus and compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input pdc_byte_t d, input pdc_resp_t er = 2'b00);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [11:0] a, input pdc_byte_t exp, input pdc_resp_t er = 2'b00);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h000000, exp});
    chk(s_axi_rresp, er);
  endtask
  task automatic summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset;
    rd(`PDC_OFF_DIR, 8'h00);
    rd(`PDC_OFF_PULL, 8'h00);
    rd(`PDC_OFF_SC, 8'h00);
    chk(pin_out | pin_oe | pull_up_en | pull_down_en, 8'h00);
    wr(`PDC_OFF_SLEW, 8'hff);
    wr(`PDC_OFF_DRIVE, 8'h55);
    wr(12'h0f0, 8'h12, `PDC_RESP_SLVERR);
    rd(12'h0f0, 8'h00, `PDC_RESP_SLVERR);
    // Lane 0 strobe low: the write is answered but changes nothing
    s_axi_wstrb <= 4'he;
    wr(`PDC_OFF_PULL, 8'hff);
    s_axi_wstrb <= 4'hf;
    rd(`PDC_OFF_PULL, 8'h00);
  endtask
  task automatic t_dir;
    ext_en <= 8'hf0;
    ext_val <= 8'h3c;
    wr(`PDC_OFF_DATA, 8'ha5);
    wr(`PDC_OFF_DIR, 8'h0f);
    repeat (8) @(posedge aclk);
    rd(`PDC_OFF_DATA, 8'h35);
    chk({pin_oe, pin_out & pin_oe}, 16'h0f05);
    chk(slew_limit_en, 8'h0f);
    chk(high_drive_en, 8'h05);
  endtask
  task automatic t_pull;
    wr(`PDC_OFF_PULL, 8'hff);
    wr(`PDC_OFF_PSEL, 8'h30);
    wr(`PDC_OFF_ESEL, 8'hf0);
    repeat (2) @(posedge aclk);
    chk(pull_up_en, 8'hc0);
    chk(pull_down_en, 8'h30);
  endtask
  task automatic t_edge;
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    wr(`PDC_OFF_DIR, 8'h00);
    wr(`PDC_OFF_PSEL, 8'h01);
    wr(`PDC_OFF_ESEL, 8'h00);
    wr(`PDC_OFF_SC, 8'h06);
    ext_val <= 8'hfd;
    repeat (8) @(posedge aclk);
    rd(`PDC_OFF_SC, 8'h02);
    ext_val <= 8'hfc;
    repeat (8) @(posedge aclk);
    rd(`PDC_OFF_SC, 8'h0a);
    chk(pin_irq_request, 1'b1);
    wr(`PDC_OFF_SC, 8'h06);
    rd(`PDC_OFF_SC, 8'h02);
    chk(pin_irq_request, 1'b0);
    wr(`PDC_OFF_SC, 8'h08);
    rd(`PDC_OFF_SC, 8'h00);
    ext_val <= 8'hff;
    repeat (8) @(posedge aclk);
    ext_val <= 8'hfe;
    repeat (8) @(posedge aclk);
    rd(`PDC_OFF_SC, 8'h08);
    chk(pin_irq_request, 1'b0);
  endtask
  task automatic t_level;
    wr(`PDC_OFF_ESEL, 8'h01);
    wr(`PDC_OFF_SC, 8'h07);
    rd(`PDC_OFF_SC, 8'h03);
    ext_val <= 8'hff;
    repeat (8) @(posedge aclk);
    rd(`PDC_OFF_SC, 8'h0b);
    wr(`PDC_OFF_SC, 8'h07);
    rd(`PDC_OFF_SC, 8'h0b);
    ext_val <= 8'hfe;
    repeat (8) @(posedge aclk);
    wr(`PDC_OFF_SC, 8'h07);
    rd(`PDC_OFF_SC, 8'h03);
  endtask
  // Reset in mid-run with pins driven and pulled
  task automatic t_rerun;
    wr(`PDC_OFF_DIR, 8'h0f);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({pin_out, pin_oe, pull_up_en, pull_down_en}, 32'h0000_0000);
    rd(`PDC_OFF_DIR, 8'h00);
    rd(`PDC_OFF_PULL, 8'h00);
    rd(`PDC_OFF_SLEW, `PDC_RST_SLEW);
    rd(`PDC_OFF_SC, 8'h00);
  endtask
  // ============================================================
  // Run
  // Tests take about two hundred cycles; fifteen times that flags a hang
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      summarize;
    end
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_dir;
    t_pull;
    t_edge;
    t_level;
    t_rerun;
    summarize;
  end
endmodule // pdc_port_tb_top
